// ### design/sdic_pkg.sv
// Constants and types shared by the interrupt combiner
package sdic_pkg;
  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int NUM_CH = 8;
  localparam int COUNT_W = 16;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] OFS_RX_MASK_SET = 8'h00;
  localparam logic [7:0] OFS_RX_MASK_CLR = 8'h04;
  localparam logic [7:0] OFS_RX_RAW = 8'h08;
  localparam logic [7:0] OFS_RX_GATED = 8'h0C;
  localparam logic [7:0] OFS_TX_MASK_SET = 8'h10;
  localparam logic [7:0] OFS_TX_MASK_CLR = 8'h14;
  localparam logic [7:0] OFS_TX_RAW = 8'h18;
  localparam logic [7:0] OFS_TX_GATED = 8'h1C;
  localparam logic [7:0] OFS_DMA_MASK_SET = 8'h20;
  localparam logic [7:0] OFS_DMA_MASK_CLR = 8'h24;
  localparam logic [7:0] OFS_DMA_RAW = 8'h28;
  localparam logic [7:0] OFS_DMA_GATED = 8'h2C;
  localparam logic [7:0] OFS_RX_ROUTE_EN = 8'h30;
  localparam logic [7:0] OFS_RX_ROUTE_STAT = 8'h34;
  localparam logic [7:0] OFS_TX_ROUTE_EN = 8'h38;
  localparam logic [7:0] OFS_TX_ROUTE_STAT = 8'h3C;
  localparam logic [7:0] OFS_LOW_ROUTE_EN = 8'h40;
  localparam logic [7:0] OFS_LOW_ROUTE_STAT = 8'h44;
  localparam logic [7:0] OFS_MISC_EN = 8'h48;
  localparam logic [7:0] OFS_MISC_STAT = 8'h4C;
  localparam logic [7:0] OFS_EOI = 8'h50;
  localparam logic [7:0] OFS_LINK_EN = 8'h54;
  localparam logic [7:0] OFS_ACCESS_MASK = 8'h58;
  localparam logic [7:0] OFS_LINK_CAPTURE = 8'h5C;
  localparam logic [7:0] OFS_ACCESS_CAPTURE = 8'h60;
  localparam logic [7:0] OFS_FAULT_CAUSE = 8'h64;
  localparam logic [7:0] OFS_PHY_SELECT = 8'h68;
  // Windows of eight words, index in address bits 4:2
  localparam logic [2:0] WIN_RX_CP = 3'h4;
  localparam logic [2:0] WIN_TX_CP = 3'h5;
  localparam logic [2:0] WIN_LIMIT = 3'h6;

  // ************************************************************
  // Fields and codes
  // ************************************************************
  localparam int DMA_BIT_STAT = 0;
  localparam int DMA_BIT_FAULT = 1;
  // Line index equals its end-of-interrupt code
  localparam int LINE_LOW = 0;
  localparam int LINE_RX = 1;
  localparam int LINE_TX = 2;
  localparam int LINE_MISC = 3;
  localparam int NUM_LINES = 4;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] RST_LIMIT = 16'h0000;
  localparam logic [3:0] RST_ARMED = 4'hF;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic write;
    logic [2:0] channel;
    logic [31:0] address;
  } sdic_cp_write_s;

  typedef logic [NUM_CH-1:0][COUNT_W-1:0] sdic_counts_t;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_DONE = 1'b1
  } sdic_bus_e;
endpackage

// ### design/sdic_top.sv
// Interrupt combiner for the switch packet DMA with Avalon-MM registers
//
// Contract
// - Four separate pulse outputs: receive, transmit, low buffer, miscellaneous.
// - Eight receive and transmit channels, each with own pending bits.
// - Writing one to a mask-set bit enables that channel; zeros ignored.
// - Writing one to a mask-clear bit disables that channel; zeros ignored.
// - Route enables gate masked completions onto pulses; status stays readable.
// - DMA completion write stores pointer and raises pending, any value.
// - Host pointer write clears pending only when it matches stored value.
// - Reading a completion pointer returns the DMA written address.
// - End-of-interrupt code one, two, three acknowledges receive, transmit, miscellaneous.
// - Transmit completion mirrors receive, with its own route enables.
// - Low buffer pulse is immediate, taken from eight threshold bits.
// - Threshold bit set while free count is at or below limit.
// - Threshold route enables with status; code zero acknowledges threshold.
// - Miscellaneous pulse from four sources gated by an enable register.
// - Counter overflow pending follows counters at or above top bit.
// - Overflow and fault events enabled by mask-set, disabled by mask-clear.
// - Descriptor fault pending is sticky until reset.
// - Six transmit descriptor fault causes are flagged.
// - Four receive descriptor fault causes are flagged.
// - Raw and gated status of overflow and fault are readable.
// - Link change of monitored PHY raises event when enabled, captured.
// - Access go falling raises event when masked in, captured.
//
// Our own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
module sdic_top (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire sdic_pkg::sdic_cp_write_s RX_CP_WRITE,
  input wire sdic_pkg::sdic_cp_write_s TX_CP_WRITE,
  input wire sdic_pkg::sdic_counts_t FREE_BUFFER_COUNT,
  input wire logic COUNTER_HIGH,
  input wire logic [5:0] TX_FAULT_FLAGS,
  input wire logic [3:0] RX_FAULT_FLAGS,
  input wire logic PHY_LINK_UP,
  input wire logic PHY_ACCESS_GO,
  output logic [4:0] MONITORED_PHY_ADDRESS,
  output logic RECEIVE_DONE_PULSE,
  output logic TRANSMIT_DONE_PULSE,
  output logic RECEIVE_LOW_BUFFER_PULSE,
  output logic MISC_EVENT_PULSE
);
  // ************************************************************
  // Declarations
  // ************************************************************
  sdic_pkg::sdic_bus_e bus_state_ff;
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic wr_fire;
  logic [31:0] bem;
  logic [31:0] wd;
  logic [2:0] win;
  logic [2:0] idx;
  logic [15:0] rx_mask_ff;
  logic [7:0] tx_mask_ff;
  logic [1:0] dma_mask_ff;
  logic [7:0] rx_route_ff;
  logic [7:0] tx_route_ff;
  logic [7:0] low_route_ff;
  logic [3:0] misc_en_ff;
  logic link_en_ff;
  logic access_mask_ff;
  logic link_cap_ff;
  logic access_cap_ff;
  logic [4:0] phy_sel_ff;
  logic [7:0] receive_done_pending_ff;
  logic [7:0] transmit_done_pending_ff;
  logic [31:0] rx_cp_ff [sdic_pkg::NUM_CH];
  logic [31:0] tx_cp_ff [sdic_pkg::NUM_CH];
  logic [15:0] limit_ff [sdic_pkg::NUM_CH];
  logic [9:0] fault_cause_ff;
  logic link_state_ff;
  logic go_ff;
  logic [3:0] armed_ff;
  logic [3:0] pulse_ff;
  logic [7:0] low_raw;
  logic [15:0] rx_raw;
  logic [15:0] rx_gated;
  logic [7:0] tx_gated;
  logic [7:0] rx_route_stat;
  logic [7:0] tx_route_stat;
  logic [7:0] low_route_stat;
  logic [1:0] dma_raw;
  logic [1:0] dma_gated;
  logic [3:0] misc_raw;
  logic [3:0] misc_stat;
  logic [3:0] line_req;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic hit(input logic [7:0] ofs);
    hit = wr_fire && (AVS_ADDRESS == ofs);
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw);
    merge = (old & ~bem) | (nw & bem);
  endfunction

  // ************************************************************
  // Avalon slave: one wait cycle, then one answer cycle
  // ************************************************************
  // A write lands only at the edge where waitrequest is seen low
  assign wr_fire = AVS_WRITE && (bus_state_ff == sdic_pkg::BUS_DONE);
  assign bem = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}}, {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
  assign wd = AVS_WRITEDATA & bem;
  assign win = AVS_ADDRESS[7:5];
  assign idx = AVS_ADDRESS[4:2];

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      bus_state_ff <= sdic_pkg::BUS_IDLE;
      wait_ff <= 1'b1;
      rdata_ff <= sdic_pkg::RST_WORD;
    end else begin
      case (bus_state_ff)
        sdic_pkg::BUS_IDLE: begin
          if (AVS_READ || AVS_WRITE) begin
            bus_state_ff <= sdic_pkg::BUS_DONE;
            wait_ff <= 1'b0;
            rdata_ff <= AVS_READ ? nxt_rdata : rdata_ff;
          end
        end
        sdic_pkg::BUS_DONE: begin
          bus_state_ff <= sdic_pkg::BUS_IDLE;
          wait_ff <= 1'b1;
        end
        default: begin
          bus_state_ff <= sdic_pkg::BUS_IDLE;
          wait_ff <= 1'b1;
        end
      endcase
    end
  end
  // Unmapped and write-only words read as zero
  always_comb begin
    nxt_rdata = sdic_pkg::RST_WORD;
    case (AVS_ADDRESS)
      sdic_pkg::OFS_RX_MASK_SET, sdic_pkg::OFS_RX_MASK_CLR: nxt_rdata = {16'h0000, rx_mask_ff};
      sdic_pkg::OFS_RX_RAW: nxt_rdata = {16'h0000, rx_raw};
      sdic_pkg::OFS_RX_GATED: nxt_rdata = {16'h0000, rx_gated};
      sdic_pkg::OFS_TX_MASK_SET, sdic_pkg::OFS_TX_MASK_CLR: nxt_rdata = {24'h000000, tx_mask_ff};
      sdic_pkg::OFS_TX_RAW: nxt_rdata = {24'h000000, transmit_done_pending_ff};
      sdic_pkg::OFS_TX_GATED: nxt_rdata = {24'h000000, tx_gated};
      sdic_pkg::OFS_DMA_MASK_SET, sdic_pkg::OFS_DMA_MASK_CLR: nxt_rdata = {30'h00000000, dma_mask_ff};
      sdic_pkg::OFS_DMA_RAW: nxt_rdata = {30'h00000000, dma_raw};
      sdic_pkg::OFS_DMA_GATED: nxt_rdata = {30'h00000000, dma_gated};
      sdic_pkg::OFS_RX_ROUTE_EN: nxt_rdata = {24'h000000, rx_route_ff};
      sdic_pkg::OFS_RX_ROUTE_STAT: nxt_rdata = {24'h000000, rx_route_stat};
      sdic_pkg::OFS_TX_ROUTE_EN: nxt_rdata = {24'h000000, tx_route_ff};
      sdic_pkg::OFS_TX_ROUTE_STAT: nxt_rdata = {24'h000000, tx_route_stat};
      sdic_pkg::OFS_LOW_ROUTE_EN: nxt_rdata = {24'h000000, low_route_ff};
      sdic_pkg::OFS_LOW_ROUTE_STAT: nxt_rdata = {24'h000000, low_route_stat};
      sdic_pkg::OFS_MISC_EN: nxt_rdata = {28'h0000000, misc_en_ff};
      sdic_pkg::OFS_MISC_STAT: nxt_rdata = {28'h0000000, misc_stat};
      sdic_pkg::OFS_LINK_EN: nxt_rdata = {31'h00000000, link_en_ff};
      sdic_pkg::OFS_ACCESS_MASK: nxt_rdata = {31'h00000000, access_mask_ff};
      sdic_pkg::OFS_LINK_CAPTURE: nxt_rdata = {31'h00000000, link_cap_ff};
      sdic_pkg::OFS_ACCESS_CAPTURE: nxt_rdata = {31'h00000000, access_cap_ff};
      sdic_pkg::OFS_FAULT_CAUSE: nxt_rdata = {22'h000000, fault_cause_ff};
      sdic_pkg::OFS_PHY_SELECT: nxt_rdata = {27'h0000000, phy_sel_ff};
      default: begin
        if (win == sdic_pkg::WIN_RX_CP) begin
          nxt_rdata = rx_cp_ff[idx];
        end else if (win == sdic_pkg::WIN_TX_CP) begin
          nxt_rdata = tx_cp_ff[idx];
        end else if (win == sdic_pkg::WIN_LIMIT) begin
          nxt_rdata = {16'h0000, limit_ff[idx]};
        end
      end
    endcase
  end

  // ************************************************************
  // Masks and routing
  // ************************************************************
  // Bits 7:0 completion, bits 15:8 low buffer threshold
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rx_mask_ff <= 16'h0000;
    end else if (hit(sdic_pkg::OFS_RX_MASK_SET)) begin
      rx_mask_ff <= rx_mask_ff | wd[15:0];
    end else if (hit(sdic_pkg::OFS_RX_MASK_CLR)) begin
      rx_mask_ff <= rx_mask_ff & ~wd[15:0];
    end
  end
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      tx_mask_ff <= 8'h00;
    end else if (hit(sdic_pkg::OFS_TX_MASK_SET)) begin
      tx_mask_ff <= tx_mask_ff | wd[7:0];
    end else if (hit(sdic_pkg::OFS_TX_MASK_CLR)) begin
      tx_mask_ff <= tx_mask_ff & ~wd[7:0];
    end
  end
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      dma_mask_ff <= 2'h0;
    end else if (hit(sdic_pkg::OFS_DMA_MASK_SET)) begin
      dma_mask_ff <= dma_mask_ff | wd[1:0];
    end else if (hit(sdic_pkg::OFS_DMA_MASK_CLR)) begin
      dma_mask_ff <= dma_mask_ff & ~wd[1:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rx_route_ff <= 8'h00;
      tx_route_ff <= 8'h00;
      low_route_ff <= 8'h00;
      misc_en_ff <= 4'h0;
      link_en_ff <= 1'b0;
      access_mask_ff <= 1'b0;
      phy_sel_ff <= 5'h00;
    end else begin
      if (hit(sdic_pkg::OFS_RX_ROUTE_EN)) rx_route_ff <= (rx_route_ff & ~bem[7:0]) | wd[7:0];
      if (hit(sdic_pkg::OFS_TX_ROUTE_EN)) tx_route_ff <= (tx_route_ff & ~bem[7:0]) | wd[7:0];
      if (hit(sdic_pkg::OFS_LOW_ROUTE_EN)) low_route_ff <= (low_route_ff & ~bem[7:0]) | wd[7:0];
      if (hit(sdic_pkg::OFS_MISC_EN)) misc_en_ff <= (misc_en_ff & ~bem[3:0]) | wd[3:0];
      if (hit(sdic_pkg::OFS_LINK_EN)) link_en_ff <= (link_en_ff & ~bem[0]) | wd[0];
      if (hit(sdic_pkg::OFS_ACCESS_MASK)) access_mask_ff <= (access_mask_ff & ~bem[0]) | wd[0];
      if (hit(sdic_pkg::OFS_PHY_SELECT)) phy_sel_ff <= (phy_sel_ff & ~bem[4:0]) | wd[4:0];
    end
  end

  // ************************************************************
  // Completion pointers and pending bits
  // ************************************************************
  // A DMA store in the same cycle as a host acknowledge wins
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      receive_done_pending_ff <= 8'h00;
      for (int i = 0; i < sdic_pkg::NUM_CH; i++) rx_cp_ff[i] <= sdic_pkg::RST_WORD;
    end else begin
      for (int i = 0; i < sdic_pkg::NUM_CH; i++) begin
        if (RX_CP_WRITE.write && (RX_CP_WRITE.channel == 3'(i))) begin
          rx_cp_ff[i] <= RX_CP_WRITE.address;
          receive_done_pending_ff[i] <= 1'b1;
        end else if (wr_fire && (win == sdic_pkg::WIN_RX_CP) && (idx == 3'(i))) begin
          if (merge(rx_cp_ff[i], AVS_WRITEDATA) == rx_cp_ff[i]) receive_done_pending_ff[i] <= 1'b0;
        end
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      transmit_done_pending_ff <= 8'h00;
      for (int i = 0; i < sdic_pkg::NUM_CH; i++) tx_cp_ff[i] <= sdic_pkg::RST_WORD;
    end else begin
      for (int i = 0; i < sdic_pkg::NUM_CH; i++) begin
        if (TX_CP_WRITE.write && (TX_CP_WRITE.channel == 3'(i))) begin
          tx_cp_ff[i] <= TX_CP_WRITE.address;
          transmit_done_pending_ff[i] <= 1'b1;
        end else if (wr_fire && (win == sdic_pkg::WIN_TX_CP) && (idx == 3'(i))) begin
          if (merge(tx_cp_ff[i], AVS_WRITEDATA) == tx_cp_ff[i]) transmit_done_pending_ff[i] <= 1'b0;
        end
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      for (int i = 0; i < sdic_pkg::NUM_CH; i++) limit_ff[i] <= sdic_pkg::RST_LIMIT;
    end else if (wr_fire && (win == sdic_pkg::WIN_LIMIT)) begin
      limit_ff[idx] <= (limit_ff[idx] & ~bem[15:0]) | wd[15:0];
    end
  end

  // ************************************************************
  // Miscellaneous sources
  // ************************************************************
  // Cleared by reset only, kept for debug of descriptor chains
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      fault_cause_ff <= 10'h000;
    end else begin
      fault_cause_ff <= fault_cause_ff | {RX_FAULT_FLAGS, TX_FAULT_FLAGS};
    end
  end
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      link_state_ff <= 1'b0;
      go_ff <= 1'b0;
    end else begin
      link_state_ff <= PHY_LINK_UP;
      go_ff <= PHY_ACCESS_GO;
    end
  end
  // Event set wins over a write-one clear in the same cycle
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      link_cap_ff <= 1'b0;
      access_cap_ff <= 1'b0;
    end else begin
      if (link_en_ff && (PHY_LINK_UP != link_state_ff)) begin
        link_cap_ff <= 1'b1;
      end else if (hit(sdic_pkg::OFS_LINK_CAPTURE) && wd[0]) begin
        link_cap_ff <= 1'b0;
      end
      if (access_mask_ff && go_ff && !PHY_ACCESS_GO) begin
        access_cap_ff <= 1'b1;
      end else if (hit(sdic_pkg::OFS_ACCESS_CAPTURE) && wd[0]) begin
        access_cap_ff <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Status and line conditions
  // ************************************************************
  always_comb begin
    for (int i = 0; i < sdic_pkg::NUM_CH; i++) begin
      low_raw[i] = FREE_BUFFER_COUNT[i] <= limit_ff[i];
    end
  end
  assign rx_raw = {low_raw, receive_done_pending_ff};
  assign rx_gated = rx_raw & rx_mask_ff;
  assign tx_gated = transmit_done_pending_ff & tx_mask_ff;
  assign rx_route_stat = rx_gated[7:0] & rx_route_ff;
  assign tx_route_stat = tx_gated & tx_route_ff;
  assign low_route_stat = rx_gated[15:8] & low_route_ff;
  assign dma_raw[sdic_pkg::DMA_BIT_STAT] = COUNTER_HIGH;
  assign dma_raw[sdic_pkg::DMA_BIT_FAULT] = |fault_cause_ff;
  assign dma_gated = dma_raw & dma_mask_ff;
  assign misc_raw = {access_cap_ff, link_cap_ff, dma_gated};
  assign misc_stat = misc_raw & misc_en_ff;
  assign line_req[sdic_pkg::LINE_LOW] = |low_route_stat;
  assign line_req[sdic_pkg::LINE_RX] = |rx_route_stat;
  assign line_req[sdic_pkg::LINE_TX] = |tx_route_stat;
  assign line_req[sdic_pkg::LINE_MISC] = |misc_stat;

  // ************************************************************
  // Pulse pacing
  // ************************************************************
  // A line fires once, then waits for its code; a pulse wins over a code in the same cycle
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      armed_ff <= sdic_pkg::RST_ARMED;
      pulse_ff <= 4'h0;
    end else begin
      for (int k = 0; k < sdic_pkg::NUM_LINES; k++) begin
        pulse_ff[k] <= armed_ff[k] && line_req[k];
        if (armed_ff[k] && line_req[k]) begin
          armed_ff[k] <= 1'b0;
        end else if (hit(sdic_pkg::OFS_EOI) && (AVS_WRITEDATA == 32'(k))) begin
          armed_ff[k] <= 1'b1;
        end
      end
    end
  end
  assign AVS_READDATA = rdata_ff;
  assign AVS_WAITREQUEST = wait_ff;
  assign MONITORED_PHY_ADDRESS = phy_sel_ff;
  assign RECEIVE_DONE_PULSE = pulse_ff[sdic_pkg::LINE_RX];
  assign TRANSMIT_DONE_PULSE = pulse_ff[sdic_pkg::LINE_TX];
  assign RECEIVE_LOW_BUFFER_PULSE = pulse_ff[sdic_pkg::LINE_LOW];
  assign MISC_EVENT_PULSE = pulse_ff[sdic_pkg::LINE_MISC];
endmodule // sdic_top

// ### test/sdic_host_model.sv
// Host model counting the four pulse lines
`timescale 1ns/100ps
module sdic_host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] pulses,
  output int cnt [4]
);
  // Each one-cycle pulse is one interrupt taken
  always @(posedge clk) begin
    if (rst) begin
      cnt <= '{default: 0};
    end else begin
      for (int i = 0; i < 4; i++) begin
        cnt[i] <= cnt[i] + int'(pulses[i]);
      end
    end
  end
endmodule // sdic_host_model

// ### test/sdic_sva.sv
// Port assertions for the interrupt combiner
`timescale 1ns/100ps
module sdic_sva (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic [5:0] TX_FAULT_FLAGS,
  input wire logic [3:0] RX_FAULT_FLAGS,
  input wire logic [4:0] MONITORED_PHY_ADDRESS,
  input wire logic RECEIVE_DONE_PULSE,
  input wire logic TRANSMIT_DONE_PULSE,
  input wire logic RECEIVE_LOW_BUFFER_PULSE,
  input wire logic MISC_EVENT_PULSE
);
  // ****
  // Shadow state
  // ****
  logic [3:0] armed_ff;
  logic [3:0] nxt_armed;
  logic [9:0] cause_ff;
  logic [3:0] pulses;
  logic eoi_wr;
  assign pulses = {MISC_EVENT_PULSE, TRANSMIT_DONE_PULSE, RECEIVE_DONE_PULSE, RECEIVE_LOW_BUFFER_PULSE};
  assign eoi_wr = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 8'h50 && AVS_BYTEENABLE == 4'hF
    && AVS_WRITEDATA[31:2] == 30'h0;
  // Acknowledge beats a pulse seen at the same edge
  always_comb begin
    nxt_armed = armed_ff & ~pulses;
    if (eoi_wr) begin
      nxt_armed[AVS_WRITEDATA[1:0]] = 1'b1;
    end
  end
  always_ff @(posedge CLK) begin
    armed_ff <= SYS_RST ? sdic_pkg::RST_ARMED : nxt_armed;
  end
  always_ff @(posedge CLK) begin
    cause_ff <= SYS_RST ? 10'h000 : cause_ff | {RX_FAULT_FLAGS, TX_FAULT_FLAGS};
  end
  // ****
  // Properties
  // ****
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  sequence rd_at(logic [7:0] a);
    AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS == a;
  endsequence
  wait_answer_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("no answer");
  wait_release_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("wait low too long");
  read_hold_a: assert property (!AVS_READ |=> $stable(AVS_READDATA))
    else $error("read data moved");
  rx_pulse_one_a: assert property (RECEIVE_DONE_PULSE |=> !RECEIVE_DONE_PULSE)
    else $error("long receive pulse");
  low_pulse_one_a: assert property ($rose(RECEIVE_LOW_BUFFER_PULSE) |=> $fell(RECEIVE_LOW_BUFFER_PULSE))
    else $error("long low buffer pulse");
  pulse_armed_a: assert property ((pulses & ~armed_ff) == 4'h0)
    else $error("pulse without acknowledge");
  phy_select_a: assert property (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 8'h68 && AVS_BYTEENABLE[0]
    |=> MONITORED_PHY_ADDRESS == $past(AVS_WRITEDATA[4:0])) else $error("phy address");
  fault_cause_a: assert property (rd_at(8'h64) |=> AVS_READDATA[9:0] == $past(cause_ff))
    else $error("fault cause");
  fault_raw_a: assert property (rd_at(8'h28) |=> AVS_READDATA[1] == |$past(cause_ff))
    else $error("fault raw");
endmodule // sdic_sva
bind sdic_top sdic_sva u_sva (.*);

// ### test/sdic_top_test.sv
// Self-checking bench for the interrupt combiner
`timescale 1ns/100ps
module sdic_top_test;
  logic CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic [7:0] AVS_ADDRESS = 8'h00;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST;
  sdic_pkg::sdic_cp_write_s RX_CP_WRITE = '0;
  sdic_pkg::sdic_cp_write_s TX_CP_WRITE = '0;
  sdic_pkg::sdic_counts_t FREE_BUFFER_COUNT = {8{16'h0100}};
  logic COUNTER_HIGH = 1'b0;
  logic [5:0] TX_FAULT_FLAGS = 6'h0;
  logic [3:0] RX_FAULT_FLAGS = 4'h0;
  logic PHY_LINK_UP = 1'b0;
  logic PHY_ACCESS_GO = 1'b0;
  logic [4:0] MONITORED_PHY_ADDRESS;
  wire [3:0] pulses;
  logic [31:0] rdata;
  int cnt [4];
  int ep [4] = '{default: 0};
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  always #25 CLK = ~CLK;
  sdic_top uut (.*, .AVS_BYTEENABLE(4'hF), .RECEIVE_LOW_BUFFER_PULSE(pulses[0]), .RECEIVE_DONE_PULSE(pulses[1]),
    .TRANSMIT_DONE_PULSE(pulses[2]), .MISC_EVENT_PULSE(pulses[3]));
  sdic_host_model host (.clk(CLK), .rst(SYS_RST), .pulses(pulses), .cnt(cnt));
  // ****
  // Tasks
  // ****
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Hold the request until waitrequest is sampled low; hangs end at the cycle ceiling
  task automatic acc(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge CLK);
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    AVS_ADDRESS <= ad;
    AVS_WRITEDATA <= wd;
    do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
    rdata = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [31:0] exp);
    acc(1'b0, ad, 32'h0);
    chk(rdata, exp);
  endtask
  task automatic dma(input logic tx, input logic [2:0] c, input logic [31:0] a);
    @(posedge CLK);
    RX_CP_WRITE <= {!tx, c, a};
    TX_CP_WRITE <= {tx, c, a};
    @(posedge CLK);
    RX_CP_WRITE <= '0;
    TX_CP_WRITE <= '0;
  endtask
  task automatic flt(input logic [5:0] t, input logic [3:0] r);
    @(posedge CLK);
    TX_FAULT_FLAGS <= t;
    RX_FAULT_FLAGS <= r;
    @(posedge CLK);
    TX_FAULT_FLAGS <= 6'h0;
    RX_FAULT_FLAGS <= 4'h0;
  endtask
  task automatic cp_test(input logic tx);
    logic [7:0] b = tx ? 8'h10 : 8'h00;
    logic [7:0] r = tx ? 8'h38 : 8'h30;
    logic [2:0] c = 3'($urandom);
    logic [7:0] p = (tx ? 8'hA0 : 8'h80) + {3'h0, c, 2'h0};
    logic [31:0] a = $urandom;
    int ln = tx ? 2 : 1;
    acc(1'b1, b, 32'h1 << c);
    rdc(b + 8'h4, 32'h1 << c);
    acc(1'b1, r, 32'h1 << c);
    dma(tx, c, a);
    rdc(b + 8'h8, 32'h1 << c);
    rdc(b + 8'hC, 32'h1 << c);
    rdc(r + 8'h4, 32'h1 << c);
    rdc(p, a);
    ep[ln]++;
    chk(cnt[ln], ep[ln]);
    acc(1'b1, p, a ^ 32'h4);
    rdc(b + 8'h8, 32'h1 << c);
    acc(1'b1, 8'h50, ln);
    ep[ln]++;
    acc(1'b1, p, a);
    rdc(b + 8'h8, 32'h0);
    chk(cnt[ln], ep[ln]);
    acc(1'b1, b + 8'h4, 32'h1 << c);
    rdc(b + 8'h4, 32'h0);
  endtask
  // Any hang is cut short here
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      summarize();
    end
  end
  // ****
  // Main sequence
  // ****
  initial begin
    void'($urandom(96));
    repeat (8) @(posedge CLK);
    SYS_RST <= 1'b0;
    cp_test(1'b0);
    cp_test(1'b1);
    $display("completion tests done");
    FREE_BUFFER_COUNT[3] <= 16'h0005;
    acc(1'b1, 8'hCC, 32'h5);
    acc(1'b1, 8'h00, 32'h800);
    acc(1'b1, 8'h40, 32'h8);
    rdc(8'h08, 32'h800);
    rdc(8'h44, 32'h8);
    ep[0]++;
    chk(cnt[0], ep[0]);
    acc(1'b1, 8'h50, 32'h0);
    ep[0]++;
    acc(1'b1, 8'hCC, 32'h4);
    rdc(8'h08, 32'h0);
    chk(cnt[0], ep[0]);
    $display("low buffer test done");
    acc(1'b1, 8'h48, 32'hF);
    acc(1'b1, 8'h20, 32'h2);
    flt(6'h1 << ($urandom % 6), 4'h0);
    rdc(8'h28, 32'h2);
    for (int i = 0; i < 6; i++) begin
      flt(6'h1 << i, 4'h1 << (i % 4));
    end
    rdc(8'h64, 32'h3FF);
    ep[3]++;
    chk(cnt[3], ep[3]);
    COUNTER_HIGH <= 1'b1;
    rdc(8'h2C, 32'h2);
    acc(1'b1, 8'h20, 32'h1);
    rdc(8'h2C, 32'h3);
    COUNTER_HIGH <= 1'b0;
    acc(1'b1, 8'h24, 32'h2);
    rdc(8'h28, 32'h2);
    rdc(8'h2C, 32'h0);
    acc(1'b1, 8'h54, 32'h1);
    PHY_LINK_UP <= 1'b1;
    PHY_ACCESS_GO <= 1'b1;
    acc(1'b1, 8'h58, 32'h1);
    PHY_ACCESS_GO <= 1'b0;
    rdc(8'h5C, 32'h1);
    rdc(8'h60, 32'h1);
    rdc(8'h4C, 32'hC);
    acc(1'b1, 8'h5C, 32'h1);
    rdc(8'h5C, 32'h0);
    rdc(8'h4C, 32'h8);
    acc(1'b1, 8'h50, 32'h3);
    ep[3]++;
    acc(1'b1, 8'h68, 32'h15);
    rdc(8'hF0, 32'h0);
    chk(cnt[3], ep[3]);
    chk(MONITORED_PHY_ADDRESS, 32'h15);
    $display("misc test done");
    summarize();
  end
endmodule // sdic_top_test
